// ---- dv/tllc_link_control_checker.sv ----
// port checker for the touch-to-indicator link control block
// assumes a bind from the bench top file and the single sys_clk domain
`timescale 1ns/1ps
module tllc_link_control_checker #(parameter int unsigned NCH = 11) (
    // watched ports, clock and reset first
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [NCH-1:0] output_control_bit,
    input wire logic [NCH-1:0] channel_is_input,
    input wire logic group_up_event,
    input wire logic [NCH-1:0] actuate,
    input wire logic [NCH-1:0] channel_enable,
    input wire logic [NCH-1:0] linked
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence up_seen;
        group_up_event ##1 linked[9];
    endsequence
    in_ignore_a: assert property (
        channel_is_input[0] |=> !linked[0])
        else $error("input channel shows as linked");
    in_quiet_a: assert property (
        channel_is_input[0] |=> !actuate[0])
        else $error("input channel actuated");
    en_link_a: assert property (
        reg_wr && reg_addr == 8'h80 && reg_wdata[0] |=> ##1
        (channel_enable[0] || $past(channel_is_input[0])))
        else $error("linked channel not enabled");
    group_excl_a: assert property (
        !(actuate[8] && actuate[9]))
        else $error("both group outputs actuated");
    up_wins_a: assert property (
        up_seen |-> ##[0:1] !actuate[8])
        else $error("down output kept after up event");
    unlinked_a: assert property (
        !channel_is_input[10] |=>
        actuate[10] == $past(output_control_bit[10]))
        else $error("unlinked channel does not follow its output bit");
    rd_unmapped_a: assert property (
        reg_rd && reg_addr == 8'h81 |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    rd_spare_a: assert property (
        reg_rd && reg_addr == 8'h78 |=> reg_rdata[7:2] == 6'h00)
        else $error("spare bits read nonzero");
endmodule // tllc_link_control_checker

// ---- dv/tllc_link_control_tb.sv ----
// bench for the link control block: register access and actuation
// assumes package and design compiled first; 100 MHz sys_clk
`timescale 1ns/1ps
module tllc_link_control_tb;
    logic sys_clk = '0, reset_n = '0, reg_wr = '0, reg_rd = '0;
    logic polarity_wr = '0, group_up_event = '0, group_down_event = '0;
    logic invert_transition_global = '0, block_auto_flip_update = '0;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
    logic [6:0] touch_present = '0;
    logic [10:0] output_polarity = '0, output_control_bit = '0, actuate;
    logic [10:0] channel_is_input = '0, channel_enable, linked;
    logic [10:0] duty_reference_flip;
    // address in the top byte, writable bits in the low byte
    logic [15:0] regs [6] = '{16'h777f, 16'h7803, 16'h79ff, 16'h7a07,
                              16'h80ff, 16'h8100};
    int bad_count = 0, checks = 0;
    tllc_link_control #(.NCH(11)) uut (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // one access per call; strobes drop a cycle before the next can rise
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge sys_clk);
        {reg_wr, reg_rd} = 2'h0;
        if (!w) cmp({3'h0, reg_rdata}, {3'h0, d});
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge sys_clk);
        reset_n = '1;
        for (int i = 0; i < 6; i++) begin
            bus(0, regs[i][15:8], 8'h00);
            bus(1, regs[i][15:8], 8'hff);
            bus(0, regs[i][15:8], regs[i][7:0]);
        end
        for (int i = 0; i < 6; i++) bus(1, regs[i][15:8], 8'h00);
        output_control_bit = 11'h007;
        bus(1, 8'h77, 8'h06);
        cmp(actuate, 11'h007);
        $display("test registers done");
        bus(1, 8'h80, 8'h07);
        @(negedge sys_clk);
        cmp(actuate, 11'h006);
        touch_present = 7'h07;
        @(negedge sys_clk);
        cmp(actuate, 11'h007);
        invert_transition_global = '1;
        channel_is_input = 11'h001;
        @(negedge sys_clk);
        cmp(actuate, 11'h000);
        cmp(linked, 11'h006);
        cmp(channel_enable, 11'h006);
        {channel_is_input, output_control_bit} = '0;
        bus(1, 8'h80, 8'h80);
        for (int i = 0; i < 2; i++) begin
            {group_up_event, group_down_event} = 2'h2 >> i;
            @(negedge sys_clk);
            {group_up_event, group_down_event} = 2'h0;
            repeat (2) @(negedge sys_clk);
            cmp(actuate, 11'h200 >> i);
        end
        $display("test linking done");
        {output_polarity, polarity_wr} = {11'h0a5, 1'h1};
        @(negedge sys_clk);
        {block_auto_flip_update, output_polarity} = '1;
        @(negedge sys_clk);
        polarity_wr = '0;
        bus(0, 8'h79, 8'ha5);
        cmp(duty_reference_flip, 11'h0a5);
        $display("test mirror done");
        results();
    end
endmodule // tllc_link_control_tb
bind tllc_link_control tllc_link_control_checker #(.NCH(NCH)) chk (.*);

// ---- rtl/tllc_link_control.sv ----
// link control: registers and per-channel actuation of indicator outputs
// assumes touch, release and group events come in synchronous to sys_clk
`timescale 1ns/1ps

module tllc_link_control #(
    parameter int unsigned NCH = tllc_pkg::NUM_CH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // configuration from neighbouring registers
    input wire logic invert_transition_global,
    input wire logic block_auto_flip_update,
    input wire logic polarity_wr,
    input wire logic [NCH-1:0] output_polarity,
    input wire logic [NCH-1:0] output_control_bit,
    input wire logic [NCH-1:0] channel_is_input,
    // sensor events
    input wire logic [tllc_pkg::NUM_LINK-1:0] touch_present,
    input wire logic group_up_event,
    input wire logic group_down_event,
    // to behavior and duty engines
    output logic [NCH-1:0] actuate,
    output logic [NCH-1:0] channel_enable,
    output logic [NCH-1:0] duty_reference_flip,
    output logic [NCH-1:0] linked
);
    import tllc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] link_transition_ctrl_a;
    logic [7:0] link_transition_ctrl_b;
    logic [7:0] duty_mirror_ctrl_a;
    logic [7:0] duty_mirror_ctrl_b;
    logic [7:0] sensor_to_indicator_link;
    logic [NCH-1:0] link_transition_effect;
    logic [NCH-1:0] sensor_channel_link;
    logic [NCH-1:0] link_q;
    logic [NCH-1:0] hold_invert;
    logic [NCH-1:0] group_active;
    logic [NCH-1:0] next_actuate;
    logic up_down_link;
    logic [7:0] next_rdata;
    logic [NCH-1:0] actuate_req;
    logic [NCH-1:0] next_exclusive;
    logic [NCH-1:0] duty_flip_bits;
    logic pair_clash;

    ////////////////////////////////////////////////////////////////////////
    // write decode
    // write strobes decoded once, one per register; auto_flip serves both mirror registers
    logic wr_trans_a;
    logic wr_trans_b;
    logic wr_mirror_a;
    logic wr_mirror_b;
    logic wr_link;
    logic auto_flip;

    assign wr_trans_a = reg_wr && (reg_addr == ADDR_TRANS_A);
    assign wr_trans_b = reg_wr && (reg_addr == ADDR_TRANS_B);
    assign wr_mirror_a = reg_wr && (reg_addr == ADDR_MIRROR_A);
    assign wr_mirror_b = reg_wr && (reg_addr == ADDR_MIRROR_B);
    assign wr_link = reg_wr && (reg_addr == ADDR_LINK);
    // blocked auto update leaves the mirror bits to software alone
    assign auto_flip = polarity_wr && !block_auto_flip_update;

    ////////////////////////////////////////////////////////////////////////
    // register write
    // unassigned bits are masked on entry so they always read back zero
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            link_transition_ctrl_a <= RESET_VALUE;
        end else if (wr_trans_a) begin
            link_transition_ctrl_a <= reg_wdata & MASK_TRANS_A;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            link_transition_ctrl_b <= RESET_VALUE;
        end else if (wr_trans_b) begin
            link_transition_ctrl_b <= reg_wdata & MASK_TRANS_B;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sensor_to_indicator_link <= RESET_VALUE;
        end else if (wr_link) begin
            sensor_to_indicator_link <= reg_wdata & MASK_LINK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mirror bits
    // a polarity write lands after any direct mirror write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_mirror_ctrl_a <= RESET_VALUE;
        end else if (auto_flip) begin
            duty_mirror_ctrl_a <= output_polarity[7:0];
        end else if (wr_mirror_a) begin
            duty_mirror_ctrl_a <= reg_wdata & MASK_MIRROR_A;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_mirror_ctrl_b <= RESET_VALUE;
        end else if (auto_flip) begin
            duty_mirror_ctrl_b <= {5'h00, output_polarity[10:8]};
        end else if (wr_mirror_b) begin
            duty_mirror_ctrl_b <= reg_wdata & MASK_MIRROR_B;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    // unmapped addresses return zero rather than the last value
    always_comb begin
        next_rdata = RESET_VALUE;
        case (reg_addr)
            ADDR_TRANS_A: begin
                next_rdata = link_transition_ctrl_a;
            end
            ADDR_TRANS_B: begin
                next_rdata = link_transition_ctrl_b;
            end
            ADDR_MIRROR_A: begin
                next_rdata = duty_mirror_ctrl_a;
            end
            ADDR_MIRROR_B: begin
                next_rdata = duty_mirror_ctrl_b;
            end
            ADDR_LINK: begin
                next_rdata = sensor_to_indicator_link;
            end
            default: begin
                next_rdata = RESET_VALUE;
            end
        endcase
    end

    // data holds between reads so a slow master can sample late
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_rdata <= RESET_VALUE;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel mapping
    assign up_down_link = sensor_to_indicator_link[UP_DOWN_BIT];
    // index 7 (channel eight) and index 10 have no sensor of their own
    assign link_transition_effect = {1'b0, link_transition_ctrl_b[1:0],
        1'b0, link_transition_ctrl_a[6:0]};
    assign sensor_channel_link = {1'b0, up_down_link, up_down_link, 1'b0,
        sensor_to_indicator_link[6:0]} & ~channel_is_input;

    // group latch: the last up or down event wins, up beats down in the same cycle; the pair stays exclusive
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !up_down_link) begin
            group_active <= '0;
        end else if (group_up_event) begin
            group_active <= '0;
            group_active[UP_CH] <= 1'b1;
        end else if (group_down_event) begin
            group_active <= '0;
            group_active[DOWN_CH] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            link_q <= '0;
        end else begin
            link_q <= sensor_channel_link;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel actuation
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic touch_i;
        logic link_rise;
        if (i < NUM_LINK) begin : g_sensor
            assign touch_i = touch_present[i];
        end else begin : g_group
            assign touch_i = group_active[i];
        end
        assign link_rise = sensor_channel_link[i] && !link_q[i];

        // hold_invert keeps the pre-link lit state so the link is seamless
        always_ff @(posedge sys_clk) begin
            if (!reset_n || !sensor_channel_link[i]) begin
                hold_invert[i] <= 1'b0;
            end else if (link_rise) begin
                hold_invert[i] <= link_transition_effect[i] &&
                    output_control_bit[i] && !touch_i;
            end
        end

        always_comb begin
            if (!sensor_channel_link[i]) begin
                next_actuate[i] = output_control_bit[i];
            end else if (link_rise) begin
                // transition clear: state follows touch at once
                next_actuate[i] = (link_transition_effect[i] &&
                    output_control_bit[i] && !touch_i) ? 1'b1 : touch_i;
            end else if (hold_invert[i]) begin
                // inverted: touch toggles off, else pinned
                next_actuate[i] = invert_transition_global ? !touch_i : 1'b1;
            end else begin
                next_actuate[i] = touch_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pair exclusion
    assign actuate_req = next_actuate & ~channel_is_input;
    assign pair_clash = actuate_req[DOWN_CH] && actuate_req[UP_CH];

    // the pair never lights together; down wins a tie only while latched down, otherwise up wins
    always_comb begin
        next_exclusive = actuate_req;
        if (pair_clash) begin
            if (group_active[DOWN_CH]) begin
                next_exclusive[UP_CH] = 1'b0;
            end else begin
                next_exclusive[DOWN_CH] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            actuate <= '0;
        end else begin
            actuate <= next_exclusive;
        end
    end

    // enable follows the link so the engine needs no enable write of its own
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            channel_enable <= '0;
        end else begin
            channel_enable <= sensor_channel_link;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            linked <= '0;
        end else begin
            linked <= sensor_channel_link;
        end
    end

    assign duty_flip_bits = {duty_mirror_ctrl_b[2:0], duty_mirror_ctrl_a};
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_reference_flip <= '0;
        end else begin
            duty_reference_flip <= duty_flip_bits;
        end
    end

endmodule // tllc_link_control

// ---- rtl/tllc_pkg.sv ----
// constants for the touch-to-indicator link control block
// assumes an 8-bit register port with byte addresses as printed
package tllc_pkg;
    localparam int unsigned NUM_CH = 11;
    localparam int unsigned NUM_LINK = 7;
    localparam logic [7:0] ADDR_TRANS_A = 8'h77;
    localparam logic [7:0] ADDR_TRANS_B = 8'h78;
    localparam logic [7:0] ADDR_MIRROR_A = 8'h79;
    localparam logic [7:0] ADDR_MIRROR_B = 8'h7a;
    localparam logic [7:0] ADDR_LINK = 8'h80;
    localparam logic [7:0] MASK_TRANS_A = 8'h7f;
    localparam logic [7:0] MASK_TRANS_B = 8'h03;
    localparam logic [7:0] MASK_MIRROR_A = 8'hff;
    localparam logic [7:0] MASK_MIRROR_B = 8'h07;
    localparam logic [7:0] MASK_LINK = 8'hff;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int unsigned UP_DOWN_BIT = 7;
    localparam int unsigned DOWN_CH = 8;
    localparam int unsigned UP_CH = 9;
endpackage
